// ### hdl/btbcc_core.sv
// executor for bit toggle, overflow/zero branch, call and clear
`timescale 1ns/1ns
`include "btbcc_cfg.svh"
module btbcc_core #(
    parameter int AW = 12,
    parameter int PW = 21
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [3:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output logic [PW-1:0] prog_addr,
    input wire logic [15:0] prog_data,
    output btbcc_pkg::btbcc_dmem_s dmem_req,
    input wire logic [7:0] dmem_rdata,
    output btbcc_pkg::btbcc_stack_s return_stack_top,
    output btbcc_pkg::btbcc_phase_e phase
);
    btbcc_pkg::btbcc_state_s s_r;
    btbcc_pkg::btbcc_state_s s_nxt;
    logic [AW-1:0] faddr;
    logic [PW-1:0] btarget;

    function automatic btbcc_pkg::btbcc_op_e decode(input logic [15:0] w);
        if (w[15:12] == `BTBCC_OPC_BTG) begin
            decode = btbcc_pkg::OP_BTG;
        end else if (w[15:8] == `BTBCC_OPC_BOV) begin
            decode = btbcc_pkg::OP_BOV;
        end else if (w[15:8] == `BTBCC_OPC_BZ) begin
            decode = btbcc_pkg::OP_BZ;
        end else if (w[15:9] == `BTBCC_OPC_CALL) begin
            decode = btbcc_pkg::OP_CALL;
        end else if (w[15:9] == `BTBCC_OPC_CLEAR_REGISTER_OP) begin
            decode = btbcc_pkg::OP_CLEAR_REGISTER_OP;
        end else begin
            decode = btbcc_pkg::OP_NOP;
        end
    endfunction

    // address is resolved from the word being fetched in the decode phase
    btbcc_fsel #(.AW(AW)) u_fsel (
        .f(prog_data[7:0]),
        .acc_sel(prog_data[8]),
        .ext_en(s_r.ext_en),
        .bank_sel(s_r.bank_select_register),
        .index(s_r.index),
        .addr(faddr)
    );

    btbcc_btgt #(.PW(PW)) u_btgt (
        .pc_inc(s_r.pc),
        .offset(s_r.instr[7:0]),
        .target(btarget)
    );

    always_comb begin
        s_nxt = s_r;
        s_nxt.dm.rd = 1'b0;
        s_nxt.dm.wr = 1'b0;
        s_nxt.stk.push = 1'b0;
        s_nxt.rdata = 32'h0000_0000;
        // register port, ahead of the core so that core updates win
        if (bus_wr) begin
            if (bus_addr == `BTBCC_REG_CTRL) begin
                s_nxt.ext_en = bus_wdata[`BTBCC_CTRL_EXT_BIT];
                s_nxt.run = bus_wdata[`BTBCC_CTRL_RUN_BIT];
            end else if (bus_addr == `BTBCC_REG_STATUS) begin
                s_nxt.status = bus_wdata[7:0];
            end else if (bus_addr == `BTBCC_REG_BANK) begin
                s_nxt.bank_select_register = bus_wdata[7:0];
            end else if (bus_addr == `BTBCC_REG_WORK) begin
                s_nxt.wreg = bus_wdata[7:0];
            end else if (bus_addr == `BTBCC_REG_INDEX) begin
                s_nxt.index = bus_wdata[AW-1:0];
            end else if (bus_addr == `BTBCC_REG_PC) begin
                s_nxt.pc = bus_wdata[PW-1:0];
            end
        end
        if (bus_rd) begin
            if (bus_addr == `BTBCC_REG_CTRL) begin
                s_nxt.rdata = {30'h0, s_r.run, s_r.ext_en};
            end else if (bus_addr == `BTBCC_REG_STATUS) begin
                s_nxt.rdata = {24'h0, s_r.status};
            end else if (bus_addr == `BTBCC_REG_BANK) begin
                s_nxt.rdata = {24'h0, s_r.bank_select_register};
            end else if (bus_addr == `BTBCC_REG_WORK) begin
                s_nxt.rdata = {24'h0, s_r.wreg};
            end else if (bus_addr == `BTBCC_REG_INDEX) begin
                s_nxt.rdata = {20'h0, s_r.index};
            end else if (bus_addr == `BTBCC_REG_PC) begin
                s_nxt.rdata = {11'h0, s_r.pc};
            end else if (bus_addr == `BTBCC_REG_SHADOW) begin
                s_nxt.rdata = {8'h0, s_r.bank_shadow, s_r.flags_shadow, s_r.working_shadow};
            end
        end
        if (s_r.run) begin
            case (s_r.phase)
                btbcc_pkg::PH_Q1: begin
                    s_nxt.phase = btbcc_pkg::PH_Q2;
                    if (s_r.flush) begin
                        s_nxt.op = btbcc_pkg::OP_NOP;
                    end else begin
                        s_nxt.instr = prog_data;
                        s_nxt.op = decode(prog_data);
                        s_nxt.pc = s_r.pc + `BTBCC_PC_STEP;
                        s_nxt.dm.addr = faddr;
                        s_nxt.dm.rd = (decode(prog_data) == btbcc_pkg::OP_BTG) ||
                            (decode(prog_data) == btbcc_pkg::OP_CLEAR_REGISTER_OP);
                    end
                end
                btbcc_pkg::PH_Q2: begin
                    s_nxt.phase = btbcc_pkg::PH_Q3;
                    if (s_r.op == btbcc_pkg::OP_CALL) begin
                        s_nxt.stk.push = 1'b1;
                        s_nxt.stk.data = s_r.pc + `BTBCC_PC_STEP;
                    end
                end
                btbcc_pkg::PH_Q3: begin
                    s_nxt.phase = btbcc_pkg::PH_Q4;
                    if (s_r.op == btbcc_pkg::OP_BTG) begin
                        s_nxt.dm.wr = 1'b1;
                        s_nxt.dm.wdata = dmem_rdata ^ (8'h01 << s_r.instr[11:9]);
                    end else if (s_r.op == btbcc_pkg::OP_CLEAR_REGISTER_OP) begin
                        s_nxt.dm.wr = 1'b1;
                        s_nxt.dm.wdata = `BTBCC_CLR_VALUE;
                        s_nxt.status[`BTBCC_Z_BIT] = 1'b1;
                    end else if (s_r.op == btbcc_pkg::OP_CALL && s_r.instr[8]) begin
                        s_nxt.working_shadow = s_r.wreg;
                        s_nxt.flags_shadow = s_r.status;
                        s_nxt.bank_shadow = s_r.bank_select_register;
                    end
                end
                btbcc_pkg::PH_Q4: begin
                    s_nxt.phase = btbcc_pkg::PH_Q1;
                    s_nxt.flush = 1'b0;
                    if ((s_r.op == btbcc_pkg::OP_BOV && s_r.status[`BTBCC_OV_BIT]) ||
                        (s_r.op == btbcc_pkg::OP_BZ && s_r.status[`BTBCC_Z_BIT])) begin
                        s_nxt.pc = btarget;
                        s_nxt.flush = 1'b1;
                    end else if (s_r.op == btbcc_pkg::OP_CALL) begin
                        // second word is on the program port in this phase
                        s_nxt.pc = {prog_data[11:0], s_r.instr[7:0], 1'b0};
                        s_nxt.flush = 1'b1;
                    end
                end
                default: begin
                    s_nxt.phase = btbcc_pkg::PH_Q1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r <= '0;
            s_r.phase <= btbcc_pkg::PH_Q1;
            s_r.op <= btbcc_pkg::OP_NOP;
            s_r.status <= `BTBCC_RST_STATUS;
            s_r.pc <= `BTBCC_RST_PC;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus_rdata = s_r.rdata;
    assign prog_addr = s_r.pc;
    assign dmem_req = s_r.dm;
    assign return_stack_top = s_r.stk;
    assign phase = s_r.phase;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic q1_run;
    logic q3_run;
    logic q4_run;
    logic f_op;
    assign q1_run = s_r.run && s_r.phase == btbcc_pkg::PH_Q1;
    assign q3_run = s_r.run && s_r.phase == btbcc_pkg::PH_Q3;
    assign q4_run = s_r.run && s_r.phase == btbcc_pkg::PH_Q4;
    assign f_op = s_r.op == btbcc_pkg::OP_BTG || s_r.op == btbcc_pkg::OP_CLEAR_REGISTER_OP;

    property p_bank_sel;
        q1_run && !s_r.flush && prog_data[8] && decode(prog_data) == btbcc_pkg::OP_BTG
        |=> s_r.dm.addr == {$past(s_r.bank_select_register[3:0]), $past(prog_data[7:0])};
    endproperty
    a_bank_sel: assert property (p_bank_sel) else $error("banked address wrong");

    property p_lit_off;
        q1_run && !s_r.flush && !prog_data[8] && s_r.ext_en && prog_data[7:0] <= `BTBCC_LITOFF_MAX
        && decode(prog_data) != btbcc_pkg::OP_NOP
        |=> s_r.dm.addr == $past(s_r.index) + {4'h0, $past(prog_data[7:0])};
    endproperty
    a_lit_off: assert property (p_lit_off) else $error("literal offset address wrong");

    property p_toggle;
        q3_run && s_r.op == btbcc_pkg::OP_BTG && !bus_wr
        |=> s_r.dm.wr && s_r.dm.wdata == ($past(dmem_rdata) ^ (8'h01 << s_r.instr[11:9]))
        && $stable(s_r.status);
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle result wrong");

    property p_bov;
        q4_run && s_r.op == btbcc_pkg::OP_BOV |=> s_r.flush == $past(s_r.status[`BTBCC_OV_BIT]);
    endproperty
    a_bov: assert property (p_bov) else $error("overflow branch decision wrong");

    property p_bz;
        q4_run && s_r.op == btbcc_pkg::OP_BZ && !s_r.status[`BTBCC_Z_BIT] && !bus_wr
        |=> !s_r.flush && s_r.pc == $past(s_r.pc);
    endproperty
    a_bz: assert property (p_bz) else $error("zero branch taken with zero clear");

    property p_target;
        q4_run && s_r.op == btbcc_pkg::OP_BZ && s_r.status[`BTBCC_Z_BIT]
        |=> $signed(s_r.pc) == $signed($past(s_r.pc)) + 2 * $signed($past(s_r.instr[7:0]));
    endproperty
    a_target: assert property (p_target) else $error("branch target wrong");

    // a halt inside the nop cycle freezes it, so only a running core must leave it
    property p_nop_cycle;
        q4_run && ((s_r.op == btbcc_pkg::OP_BOV && s_r.status[`BTBCC_OV_BIT]) ||
        (s_r.op == btbcc_pkg::OP_BZ && s_r.status[`BTBCC_Z_BIT]))
        |=> s_r.flush[*4] ##1 (!s_r.flush || !s_r.run);
    endproperty
    a_nop_cycle: assert property (p_nop_cycle) else $error("taken branch nop cycle length");

    property p_push;
        s_r.stk.push |-> s_r.stk.data == s_r.pc + `BTBCC_PC_STEP && s_r.phase == btbcc_pkg::PH_Q3;
    endproperty
    a_push: assert property (p_push) else $error("pushed return address wrong");

    property p_shadow;
        q3_run && s_r.op == btbcc_pkg::OP_CALL
        |=> s_r.working_shadow == ($past(s_r.instr[8]) ? $past(s_r.wreg) : $past(s_r.working_shadow));
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow copy wrong");

    property p_call_pc;
        q4_run && s_r.op == btbcc_pkg::OP_CALL && !bus_wr
        |=> s_r.pc == {$past(prog_data[11:0]), $past(s_r.instr[7:0]), 1'b0} ##4 !s_r.flush;
    endproperty
    a_call_pc: assert property (p_call_pc) else $error("call target or length wrong");

    property p_clear;
        q3_run && s_r.op == btbcc_pkg::OP_CLEAR_REGISTER_OP
        |=> s_r.dm.wr && s_r.dm.wdata == `BTBCC_CLR_VALUE && s_r.status[`BTBCC_Z_BIT];
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not write zero");

    property p_phases;
        (s_r.dm.rd |-> s_r.phase == btbcc_pkg::PH_Q2 && f_op)
        and (s_r.dm.wr |-> s_r.phase == btbcc_pkg::PH_Q4 && f_op);
    endproperty
    a_phases: assert property (p_phases) else $error("memory access in wrong phase");

    property p_bov_target;
        q4_run && s_r.op == btbcc_pkg::OP_BOV && s_r.status[`BTBCC_OV_BIT]
        |=> s_r.pc == $past(s_r.pc) + {{12{$past(s_r.instr[7])}}, $past(s_r.instr[7:0]), 1'b0};
    endproperty
    a_bov_target: assert property (p_bov_target) else $error("overflow branch target wrong");

    property p_not_taken;
        q4_run && ((s_r.op == btbcc_pkg::OP_BOV && !s_r.status[`BTBCC_OV_BIT]) ||
        (s_r.op == btbcc_pkg::OP_BZ && !s_r.status[`BTBCC_Z_BIT]))
        |=> !s_r.flush && s_r.phase == btbcc_pkg::PH_Q1;
    endproperty
    a_not_taken: assert property (p_not_taken) else $error("untaken branch not single cycle");

    property p_shadow_rest;
        q3_run && s_r.op == btbcc_pkg::OP_CALL
        |=> s_r.flags_shadow == ($past(s_r.instr[8]) ? $past(s_r.status) : $past(s_r.flags_shadow))
        && s_r.bank_shadow == ($past(s_r.instr[8]) ? $past(s_r.bank_select_register) : $past(s_r.bank_shadow));
    endproperty
    a_shadow_rest: assert property (p_shadow_rest) else $error("flag or bank shadow wrong");

    property p_file_read;
        q1_run && !s_r.flush && decode(prog_data) == btbcc_pkg::OP_CLEAR_REGISTER_OP
        |=> s_r.dm.rd && s_r.phase == btbcc_pkg::PH_Q2;
    endproperty
    a_file_read: assert property (p_file_read) else $error("clear did not read in second phase");

    property p_access_hi;
        q1_run && !s_r.flush && !prog_data[8] && prog_data[7:0] >= `BTBCC_ACCESS_SPLIT
        && decode(prog_data) != btbcc_pkg::OP_NOP
        |=> s_r.dm.addr == {`BTBCC_SFR_BANK, $past(prog_data[7:0])};
    endproperty
    a_access_hi: assert property (p_access_hi) else $error("upper access bank address wrong");

    c_btg: cover property (s_r.dm.wr && s_r.op == btbcc_pkg::OP_BTG);
    c_bz: cover property (q4_run && s_r.op == btbcc_pkg::OP_BZ && s_r.status[`BTBCC_Z_BIT]);
    c_bov: cover property (q4_run && s_r.op == btbcc_pkg::OP_BOV && s_r.status[`BTBCC_OV_BIT]);
    c_call_s: cover property (q4_run && s_r.op == btbcc_pkg::OP_CALL && s_r.instr[8]);
    c_clear_register_op: cover property (s_r.dm.wr && s_r.op == btbcc_pkg::OP_CLEAR_REGISTER_OP);
endmodule

// ### inc/btbcc_cfg.svh
// constants for the bit toggle / branch / call / clear executor
`ifndef BTBCC_CFG_SVH
`define BTBCC_CFG_SVH
`define BTBCC_OPC_BTG 4'h7
`define BTBCC_OPC_BOV 8'hE4
`define BTBCC_OPC_BZ 8'hE0
`define BTBCC_OPC_CALL 7'h76
`define BTBCC_OPC_CLEAR_REGISTER_OP 7'h35
`define BTBCC_Z_BIT 2
`define BTBCC_OV_BIT 3
`define BTBCC_LITOFF_MAX 8'h5F
`define BTBCC_ACCESS_SPLIT 8'h60
`define BTBCC_SFR_BANK 4'hF
`define BTBCC_PC_STEP 21'h000002
`define BTBCC_CLR_VALUE 8'h00
`define BTBCC_REG_CTRL 4'h0
`define BTBCC_REG_STATUS 4'h1
`define BTBCC_REG_BANK 4'h2
`define BTBCC_REG_WORK 4'h3
`define BTBCC_REG_INDEX 4'h4
`define BTBCC_REG_PC 4'h5
`define BTBCC_REG_SHADOW 4'h6
`define BTBCC_CTRL_EXT_BIT 0
`define BTBCC_CTRL_RUN_BIT 1
`define BTBCC_RST_STATUS 8'h00
`define BTBCC_RST_PC 21'h000000
`endif

// ### inc/btbcc_pkg.sv
// types for the bit toggle / branch / call / clear executor
package btbcc_pkg;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} btbcc_phase_e;
    typedef enum logic [2:0] {OP_NOP, OP_BTG, OP_BOV, OP_BZ, OP_CALL, OP_CLEAR_REGISTER_OP} btbcc_op_e;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } btbcc_dmem_s;
    typedef struct packed {
        logic push;
        logic [20:0] data;
    } btbcc_stack_s;
    typedef struct packed {
        btbcc_phase_e phase;
        btbcc_op_e op;
        logic [15:0] instr;
        logic [20:0] pc;
        logic flush;
        logic run;
        logic ext_en;
        logic [7:0] status;
        logic [7:0] bank_select_register;
        logic [7:0] wreg;
        logic [11:0] index;
        logic [7:0] working_shadow;
        logic [7:0] flags_shadow;
        logic [7:0] bank_shadow;
        btbcc_dmem_s dm;
        btbcc_stack_s stk;
        logic [31:0] rdata;
    } btbcc_state_s;
endpackage

// ### hdl/btbcc_fsel.sv
// file operand address resolution: bank, access bank, literal offset
`timescale 1ns/1ns
`include "btbcc_cfg.svh"
module btbcc_fsel #(
    parameter int AW = 12
) (
    input wire logic [7:0] f,
    input wire logic acc_sel,
    input wire logic ext_en,
    input wire logic [7:0] bank_sel,
    input wire logic [AW-1:0] index,
    output logic [AW-1:0] addr
);
    always_comb begin
        if (acc_sel) begin
            addr = {bank_sel[AW-9:0], f};
        end else if (ext_en && f <= `BTBCC_LITOFF_MAX) begin
            addr = index + {{(AW-8){1'b0}}, f};
        end else if (f < `BTBCC_ACCESS_SPLIT) begin
            addr = {{(AW-8){1'b0}}, f};
        end else begin
            addr = {`BTBCC_SFR_BANK, f};
        end
    end
endmodule

// ### hdl/btbcc_btgt.sv
// relative branch target: incremented pc plus doubled signed offset
`timescale 1ns/1ns
module btbcc_btgt #(
    parameter int PW = 21
) (
    input wire logic [PW-1:0] pc_inc,
    input wire logic [7:0] offset,
    output logic [PW-1:0] target
);
    always_comb begin
        target = pc_inc + {{(PW-9){offset[7]}}, offset, 1'b0};
    end
endmodule

// ### bench/btbcc_bench.sv
// self-checking bench for the bit toggle / branch / call / clear executor
`timescale 1ns/1ns
module btbcc_bench;
    logic clk_sys;
    logic reset;
    logic [3:0] bus_addr;
    logic [31:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic [31:0] bus_rdata;
    logic [20:0] prog_addr;
    logic [15:0] prog_data;
    btbcc_pkg::btbcc_dmem_s dmem_req;
    logic [7:0] dmem_rdata;
    btbcc_pkg::btbcc_stack_s return_stack_top;
    btbcc_pkg::btbcc_phase_e phase;
    logic [7:0] dmem [0:4095];
    logic [15:0] pmem [0:127];
    int cyc;
    int fails;
    int num_checks;
    int wr_t[$];
    int push_t[$];
    int rd_t[$];
    logic [20:0] push_d[$];
    logic [31:0] rv;

    btbcc_core #(.AW(12), .PW(21)) i_btbcc_core (
        .clk_sys(clk_sys),
        .reset(reset),
        .bus_addr(bus_addr),
        .bus_wdata(bus_wdata),
        .bus_wr(bus_wr),
        .bus_rd(bus_rd),
        .bus_rdata(bus_rdata),
        .prog_addr(prog_addr),
        .prog_data(prog_data),
        .dmem_req(dmem_req),
        .dmem_rdata(dmem_rdata),
        .return_stack_top(return_stack_top),
        .phase(phase)
    );

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // program memory answers in the same cycle
    assign prog_data = pmem[prog_addr[7:1]];

    // data memory with one cycle read latency, plus event log
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        dmem_rdata <= dmem[dmem_req.addr];
        if (dmem_req.wr === 1'b1) begin
            dmem[dmem_req.addr] <= dmem_req.wdata;
            wr_t.push_back(cyc);
        end
        if (dmem_req.rd === 1'b1) begin
            rd_t.push_back(cyc);
        end
        if (return_stack_top.push === 1'b1) begin
            push_t.push_back(cyc);
            push_d.push_back(return_stack_top.data);
        end
        if (cyc == 3000) begin
            fails++;
            $display("[FAIL] %0t run did not finish", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        cyc = 0;
        fails = 0;
        num_checks = 0;
        reset = 1'b1;
        bus_addr = 4'h0;
        bus_wdata = 32'h00000000;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        dmem_rdata = 8'h00;
        for (int i = 0; i < 4096; i++) begin
            dmem[i] = 8'h00;
        end
        for (int i = 0; i < 128; i++) begin
            pmem[i] = 16'h0000;
        end
        dmem[12'h310] = 8'h75;
        dmem[12'h120] = 8'h01;
        dmem[12'hF70] = 8'hFF;
        dmem[12'h355] = 8'hAA;
        dmem[12'h356] = 8'hAA;
        // toggle, untaken zero branch, toggle, clear, two taken branches, call
        pmem[0] = 16'h7910;
        pmem[1] = 16'hE005;
        pmem[2] = 16'h7020;
        pmem[3] = 16'h6A70;
        pmem[4] = 16'hE401;
        pmem[5] = 16'h6B55;
        pmem[6] = 16'hE001;
        pmem[7] = 16'h6B56;
        pmem[8] = 16'hED20;
        pmem[9] = 16'hF000;
        // overflow loop, then call without shadow save, then zero loop
        pmem[32] = 16'hE4FF;
        pmem[33] = 16'hEC30;
        pmem[34] = 16'hF000;
        pmem[48] = 16'hE0FF;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        bus_read(4'h1, rv);
        chk(rv, 32'h00000000);
        bus_read(4'h5, rv);
        chk(rv, 32'h00000000);
        bus_read(4'hF, rv);
        chk(rv, 32'h00000000);
        chk(phase, btbcc_pkg::PH_Q1);
        bus_write(4'h3, 32'h0000005A);
        bus_write(4'h2, 32'h00000003);
        bus_write(4'h1, 32'h00000008);
        bus_write(4'h4, 32'h00000100);
        bus_read(4'h1, rv);
        chk(rv, 32'h00000008);
        @(posedge clk_sys);
        #1 chk(bus_rdata, 32'h00000000);
        bus_write(4'h0, 32'h00000003);
        repeat (80) @(posedge clk_sys);
        chk({24'h000000, dmem[12'h310]}, 32'h00000065);
        chk({24'h000000, dmem[12'h120]}, 32'h00000000);
        chk({24'h000000, dmem[12'hF70]}, 32'h00000000);
        chk({24'h000000, dmem[12'h355]}, 32'h000000AA);
        chk({24'h000000, dmem[12'h356]}, 32'h000000AA);
        chk(wr_t.size(), 3);
        chk(wr_t[1] - wr_t[0], 8);
        chk(wr_t[2] - wr_t[1], 4);
        chk(rd_t.size(), 3);
        chk(wr_t[0] - rd_t[0], 2);
        chk(push_t[0] - wr_t[2], 19);
        chk({11'h000, push_d[0]}, 32'h00000014);
        bus_read(4'h5, rv);
        chk({31'h00000000, (rv === 32'h00000040) || (rv === 32'h00000042)}, 32'h00000001);
        bus_read(4'h1, rv);
        chk(rv, 32'h0000000C);
        bus_read(4'h6, rv);
        chk(rv, 32'h00030C5A);
        bus_write(4'h3, 32'h00000011);
        bus_write(4'h1, 32'h00000004);
        repeat (60) @(posedge clk_sys);
        bus_write(4'h0, 32'h00000001);
        chk(push_t.size(), 2);
        chk({11'h000, push_d[1]}, 32'h00000046);
        bus_read(4'h6, rv);
        chk(rv, 32'h00030C5A);
        bus_read(4'h5, rv);
        chk({31'h00000000, (rv === 32'h00000060) || (rv === 32'h00000062)}, 32'h00000001);
        chk(wr_t.size(), 3);
        complete_run();
    end
endmodule
